// >>> design/tlbc_top.v
// loopback control for one transceiver channel with wishbone registers
// assumes synchronous pins on mclk and a classic wishbone master
//
// Design decisions made here: the register offsets and the Wishbone register port.
`include "tlbc_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module tlbc_top #(
  parameter DW = 20
) (
  input  wire          mclk,
  input  wire          arst_n,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  input  wire [1:0]    chan_cfg,
  input  wire [1:0]    pipe_rate,
  input  wire          detect_loop_req,
  input  wire          rx_line_in,
  input  wire          tx_ser_bit,
  input  wire          cdr_ser_bit,
  input  wire          cdr_locked,
  input  wire [DW-1:0] fab_tx_word,
  input  wire [DW-1:0] rm_word,
  input  wire [DW-1:0] rx_word,
  output reg           rx_src_bit,
  output reg           tx_line_out,
  output reg  [DW-1:0] ser_word,
  output reg  [DW-1:0] rx_parallel_data,
  output reg  [1:0]    loop_mode,
  output reg  [5:0]    output_drive_level,
  output reg  [4:0]    post_tap1,
  output reg           rx_digital_reset
);

  //////////////////////////////////////////////////////////////////////////////
  // register storage
  reg  [1:0]    ctrl_reg;
  reg  [1:0]    mode_next;
  reg           chg_pulse_reg;
  reg           unsup_reg;
  wire          rst_busy;
  wire          mux_rx;
  wire          mux_line;
  wire [DW-1:0] mux_word;
  wire          wb_req;
  wire          wr_ctrl;
  wire          wr_ana;

  // address decode shared by read and write
  function is_ofs;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      is_ofs = (adr == ofs);
    end
  endfunction

  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = wb_req && wb_we_i && wb_sel_i[0] && is_ofs(wb_adr_i, `TLBC_OFS_CTRL);
  assign wr_ana  = wb_req && wb_we_i && is_ofs(wb_adr_i, `TLBC_OFS_ANALOG);

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after request, unmapped reads zero
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        if (is_ofs(wb_adr_i, `TLBC_OFS_CTRL))
          wb_dat_o <= {30'h00000000, ctrl_reg};
        else if (is_ofs(wb_adr_i, `TLBC_OFS_ANALOG))
          wb_dat_o <= {19'h00000, post_tap1, 2'h0, output_drive_level};
        else if (is_ofs(wb_adr_i, `TLBC_OFS_STATUS))
          wb_dat_o <= {26'h0000000, unsup_reg, cdr_locked, rx_digital_reset,
                       detect_loop_req, loop_mode};
        else if (is_ofs(wb_adr_i, `TLBC_OFS_CONFIG))
          wb_dat_o <= {28'h0000000, pipe_rate, chan_cfg};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control and analog registers
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg           <= `TLBC_CTRL_RST;
      output_drive_level <= `TLBC_DRV_RST;
      post_tap1          <= `TLBC_TAP_RST;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= wb_dat_i[`TLBC_CTRL_RSER_BIT:`TLBC_CTRL_SER_BIT];
      // drive and tap writable in every mode
      if (wr_ana && wb_sel_i[0])
        output_drive_level <= wb_dat_i[`TLBC_DRV_MSB:`TLBC_DRV_LSB];
      if (wr_ana && wb_sel_i[1])
        post_tap1 <= wb_dat_i[`TLBC_TAP_MSB:`TLBC_TAP_LSB];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode resolution from configuration, request pin and register bits
  always @* begin
    mode_next = `TLBC_MODE_NORMAL;
    if (chan_cfg == `TLBC_CFG_PIPE) begin
      // only reverse parallel in pipe, gen1 or gen2
      if (detect_loop_req && (pipe_rate == `TLBC_RATE_GEN1 ||
                              pipe_rate == `TLBC_RATE_GEN2))
        mode_next = `TLBC_MODE_REVPAR;
    end else if (ctrl_reg[`TLBC_CTRL_SER_BIT]) begin
      mode_next = `TLBC_MODE_SERIAL;
    end else if (ctrl_reg[`TLBC_CTRL_RSER_BIT]) begin
      mode_next = `TLBC_MODE_REVSER;
    end
    // request pin outside pipe is ignored, incl. high_rate_channel
  end

  // flag register-selected loopback that pipe configuration refuses
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      loop_mode     <= `TLBC_MODE_NORMAL;
      chg_pulse_reg <= 1'b0;
      unsup_reg     <= 1'b0;
    end else begin
      loop_mode     <= mode_next;
      chg_pulse_reg <= (mode_next != loop_mode);
      unsup_reg     <= (chan_cfg == `TLBC_CFG_PIPE) && (ctrl_reg != `TLBC_CTRL_RST);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive reset held while recovery re-tracks after a change
  tlbc_rst_stretch #(
    .CW (4)
  ) u_stretch (
    .mclk   (mclk),
    .arst_n (arst_n),
    .trig   (chg_pulse_reg),
    .hold   (`TLBC_RST_HOLD_CYC),
    .busy   (rst_busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // data path selection
  tlbc_mux #(
    .DW (DW)
  ) u_mux (
    .mode     (loop_mode),
    .line_in  (rx_line_in),
    .tx_ser   (tx_ser_bit),
    .cdr_ser  (cdr_ser_bit),
    .fab_tx   (fab_tx_word),
    .rm_word  (rm_word),
    .rx_src   (mux_rx),
    .line_out (mux_line),
    .ser_word (mux_word)
  );

  // register the path outputs
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_src_bit       <= 1'b0;
      tx_line_out      <= 1'b0;
      ser_word         <= {DW{1'b0}};
      rx_parallel_data <= {DW{1'b0}};
      rx_digital_reset <= 1'b0;
    end else begin
      rx_src_bit       <= mux_rx;
      tx_line_out      <= mux_line;
      ser_word         <= mux_word;
      rx_parallel_data <= rx_word;
      rx_digital_reset <= rst_busy || chg_pulse_reg;
    end
  end

endmodule // tlbc_top

// >>> design/tlbc_consts.vh
// constants for the transceiver loopback control block
// assumes a single 200 MHz clock and a classic wishbone register port
`ifndef TLBC_CONSTS_VH
`define TLBC_CONSTS_VH

// register byte offsets
`define TLBC_OFS_CTRL      8'h00
`define TLBC_OFS_ANALOG    8'h04
`define TLBC_OFS_STATUS    8'h08
`define TLBC_OFS_CONFIG    8'h0C

// control register fields
`define TLBC_CTRL_SER_BIT  0
`define TLBC_CTRL_RSER_BIT 1

// analog register fields
`define TLBC_DRV_LSB       0
`define TLBC_DRV_MSB       5
`define TLBC_TAP_LSB       8
`define TLBC_TAP_MSB       12

// reset values
`define TLBC_CTRL_RST      2'h0
`define TLBC_DRV_RST       6'h20
`define TLBC_TAP_RST       5'h00

// loopback mode codes on the status port
`define TLBC_MODE_NORMAL   2'h0
`define TLBC_MODE_SERIAL   2'h1
`define TLBC_MODE_REVPAR   2'h2
`define TLBC_MODE_REVSER   2'h3

// channel configurations
`define TLBC_CFG_BASIC     2'h0
`define TLBC_CFG_PIPE      2'h1
`define TLBC_CFG_NOPCS     2'h2

// rate codes
`define TLBC_RATE_GEN1     2'h0
`define TLBC_RATE_GEN2     2'h1

// receive digital reset hold after a loopback change
`define TLBC_RST_HOLD_CYC  4'h2

`endif

// >>> design/tlbc_rst_stretch.v
// stretches receive digital reset after any loopback change
// assumes mclk domain inputs; trig is a one-cycle pulse
module tlbc_rst_stretch #(
  parameter CW = 4
) (
  input  wire          mclk,
  input  wire          arst_n,
  input  wire          trig,
  input  wire [CW-1:0] hold,
  output reg           busy
);

  reg [CW-1:0] cnt_reg;

  // count down the hold time, restart on a new trigger
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= {CW{1'b0}};
      busy    <= 1'b0;
    end else if (trig) begin
      cnt_reg <= hold;
      busy    <= 1'b1;
    end else if (cnt_reg > {{(CW-1){1'b0}}, 1'b1}) begin
      cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
    end else begin
      cnt_reg <= {CW{1'b0}};
      busy    <= 1'b0;
    end
  end

endmodule // tlbc_rst_stretch

// >>> design/tlbc_mux.v
// per-cycle data path selection for the looped channel
// assumes all words are in the mclk domain
`include "tlbc_consts.vh"

module tlbc_mux #(
  parameter DW = 20
) (
  input  wire [1:0]    mode,
  input  wire          line_in,
  input  wire          tx_ser,
  input  wire          cdr_ser,
  input  wire [DW-1:0] fab_tx,
  input  wire [DW-1:0] rm_word,
  output reg           rx_src,
  output reg           line_out,
  output reg  [DW-1:0] ser_word
);

  // choose receiver source, serializer word and line driver
  always @* begin
    rx_src   = line_in;
    line_out = tx_ser;
    ser_word = fab_tx;
    case (mode)
      `TLBC_MODE_SERIAL: begin
        rx_src = tx_ser;
      end
      `TLBC_MODE_REVPAR: begin
        ser_word = rm_word;
      end
      `TLBC_MODE_REVSER: begin
        line_out = cdr_ser;
      end
      default: begin
        rx_src = line_in;
      end
    endcase
  end

endmodule // tlbc_mux

// >>> dv/tlbc_chk.sv
// checker for the loopback control top, sees its ports only
// assumes one mclk domain and the register-to-path latencies of the block
`include "tlbc_consts.vh"
module tlbc_chk #(parameter DW = 20) (
  input wire logic          mclk, arst_n, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic          detect_loop_req, rx_line_in, tx_ser_bit, cdr_ser_bit,
  input wire logic          rx_src_bit, tx_line_out, rx_digital_reset,
  input wire logic [1:0]    chan_cfg, pipe_rate, loop_mode,
  input wire logic [DW-1:0] fab_tx_word, rm_word, rx_word, ser_word, rx_parallel_data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // request that the reverse parallel mode may follow
  wire rp_ok = chan_cfg == `TLBC_CFG_PIPE && pipe_rate <= `TLBC_RATE_GEN2 && detect_loop_req;
  rx_path_a: assert property ($past(arst_n) |-> rx_src_bit ==
    $past(loop_mode == `TLBC_MODE_SERIAL ? tx_ser_bit : rx_line_in)) else $error("rx source");
  line_out_a: assert property ($past(arst_n) |-> tx_line_out ==
    $past(loop_mode == `TLBC_MODE_REVSER ? cdr_ser_bit : tx_ser_bit)) else $error("line out");
  ser_word_a: assert property ($past(arst_n) |-> ser_word ==
    $past(loop_mode == `TLBC_MODE_REVPAR ? rm_word : fab_tx_word)) else $error("ser word");
  rx_data_a: assert property ($past(arst_n) |-> rx_parallel_data == $past(rx_word))
    else $error("rx data");
  pipe_modes_a: assert property ($past(arst_n) && $past(chan_cfg) == `TLBC_CFG_PIPE |->
    loop_mode inside {`TLBC_MODE_NORMAL, `TLBC_MODE_REVPAR}) else $error("pipe mode");
  revpar_enter_a: assert property ($past(arst_n) && $past(rp_ok) |->
    loop_mode == `TLBC_MODE_REVPAR) else $error("revpar not entered");
  revpar_only_a: assert property ($past(arst_n) && loop_mode == `TLBC_MODE_REVPAR |->
    $past(rp_ok)) else $error("revpar without request");
  reset_hold_a: assert property ($past(arst_n) && loop_mode != $past(loop_mode) |=>
    rx_digital_reset [*3]) else $error("rx reset short");
  wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing");
  cover property (loop_mode == `TLBC_MODE_SERIAL);
  cover property (loop_mode == `TLBC_MODE_REVPAR);
  cover property (loop_mode == `TLBC_MODE_REVSER);
endmodule // tlbc_chk
bind tlbc_top tlbc_chk #(.DW(DW)) u_chk (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .detect_loop_req(detect_loop_req),
  .rx_line_in(rx_line_in), .tx_ser_bit(tx_ser_bit), .cdr_ser_bit(cdr_ser_bit),
  .rx_src_bit(rx_src_bit), .tx_line_out(tx_line_out), .rx_digital_reset(rx_digital_reset),
  .chan_cfg(chan_cfg), .pipe_rate(pipe_rate), .loop_mode(loop_mode), .fab_tx_word(fab_tx_word),
  .rm_word(rm_word), .rx_word(rx_word), .ser_word(ser_word), .rx_parallel_data(rx_parallel_data));

// >>> dv/tlbc_far.sv
// fabric side and line model: random serial bits and words
// assumes it watches the loop mode to send an alignment word
`include "tlbc_consts.vh"
module tlbc_far #(parameter DW = 20, parameter logic [DW-1:0] ALIGN = 20'h0F0F3) (
  input  wire logic          mclk,
  input  wire logic [1:0]    loop_mode,
  output logic               rx_line_in = 1'h0, tx_ser_bit = 1'h0, cdr_ser_bit = 1'h0,
  output logic [DW-1:0]      fab_tx_word = '0, rm_word = '0, rx_word = '0
);
  timeunit 1ns;
  timeprecision 100ps;
  // new values every cycle, alignment word while looped locally
  always @(posedge mclk) begin
    {rx_line_in, tx_ser_bit, cdr_ser_bit} <= 3'($urandom);
    rm_word <= DW'($urandom);
    rx_word <= DW'($urandom);
    fab_tx_word <= loop_mode == `TLBC_MODE_SERIAL ? ALIGN : DW'($urandom);
  end
endmodule // tlbc_far

// >>> dv/testbench.sv
// self-checking bench for the loopback control top
// assumes a 200 MHz mclk and the wishbone register map of the block
`include "tlbc_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, arst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, detect_loop_req = 0;
  logic cdr_locked = 1, wb_ack_o, rx_line_in, tx_ser_bit, cdr_ser_bit, rx_src_bit;
  logic tx_line_out, rx_digital_reset;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [1:0] chan_cfg = 0, pipe_rate = 0, loop_mode, k;
  logic [19:0] fab_tx_word, rm_word, rx_word, ser_word, rx_parallel_data;
  logic [5:0] output_drive_level;
  logic [4:0] post_tap1;
  int err_count = 0, cmp_count = 0;
  tlbc_top #(.DW(20)) dut (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_cfg(chan_cfg),
    .pipe_rate(pipe_rate), .detect_loop_req(detect_loop_req), .rx_line_in(rx_line_in),
    .tx_ser_bit(tx_ser_bit), .cdr_ser_bit(cdr_ser_bit), .cdr_locked(cdr_locked),
    .fab_tx_word(fab_tx_word), .rm_word(rm_word), .rx_word(rx_word), .rx_src_bit(rx_src_bit),
    .tx_line_out(tx_line_out), .ser_word(ser_word), .rx_parallel_data(rx_parallel_data),
    .loop_mode(loop_mode), .output_drive_level(output_drive_level), .post_tap1(post_tap1),
    .rx_digital_reset(rx_digital_reset));
  tlbc_far #(.DW(20)) far (.mclk(mclk), .loop_mode(loop_mode), .rx_line_in(rx_line_in),
    .tx_ser_bit(tx_ser_bit), .cdr_ser_bit(cdr_ser_bit), .fab_tx_word(fab_tx_word),
    .rm_word(rm_word), .rx_word(rx_word));
  initial forever #2.5 mclk = ~mclk;
  task chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one classic cycle: hold until ack is sampled, then release
  task wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1; wb_stb_i <= 1'h1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
    do begin @(posedge mclk); n++; end while (wb_ack_o !== 1'h1 && n < 40);
    q = wb_dat_o;
    chk("ack", 32'(n < 40), 32'h1);
    wb_cyc_i <= 1'h0; wb_stb_i <= 1'h0;
    @(posedge mclk);
  endtask
  // loop mode expected from configuration, rate, request pin and control bits
  function logic [1:0] em(input logic [1:0] c, r, input logic p, input logic [1:0] m);
    if (c == `TLBC_CFG_PIPE) return p && r <= `TLBC_RATE_GEN2 ? `TLBC_MODE_REVPAR : 2'h0;
    return m[0] ? `TLBC_MODE_SERIAL : m[1] ? `TLBC_MODE_REVSER : `TLBC_MODE_NORMAL;
  endfunction
  initial begin
    static logic [6:0] t [11] = '{7'h01, 7'h03, 7'h06, 7'h00, 7'h21, 7'h24, 7'h2C, 7'h34,
                                  7'h3E, 7'h44, 7'h46};
    logic [6:0] s;
    logic [10:0] an;
    logic lk;
    void'($urandom(32'h984D6C6C));
    repeat (2) @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk);
    chk("drive_rst", output_drive_level, `TLBC_DRV_RST);
    chk("mode_rst", loop_mode, `TLBC_MODE_NORMAL);
    wb(8'h40, 1'h0, 32'h0);
    chk("unmapped", q, 32'h0);
    for (int i = 0; i < 30; i++) begin
      s = i < 11 ? t[i] : 7'($urandom);
      if (s[6:5] == 2'h3) s[6:5] = 2'h0;
      chan_cfg <= s[6:5]; pipe_rate <= s[4:3]; detect_loop_req <= s[2]; k = s[1:0];
      lk = 1'($urandom);
      cdr_locked <= lk;
      wb(`TLBC_OFS_CTRL, 1'h1, {30'h0, k});
      repeat (4) @(posedge mclk);
      chk("mode", loop_mode, em(s[6:5], s[4:3], s[2], k));
      wb(`TLBC_OFS_STATUS, 1'h0, 32'h0);
      chk("status", q[5:0], {s[6:5] == `TLBC_CFG_PIPE && k != 2'h0, lk, 1'h0, s[2],
                             em(s[6:5], s[4:3], s[2], k)});
      wb(`TLBC_OFS_CTRL, 1'h0, 32'h0);
      chk("ctrl", q, {30'h0, k});
      wb(`TLBC_OFS_CONFIG, 1'h0, 32'h0);
      chk("config", q[3:0], {s[4:3], s[6:5]});
      if (loop_mode == `TLBC_MODE_REVSER) begin
        an = 11'($urandom);
        wb(`TLBC_OFS_ANALOG, 1'h1, {19'h0, an[10:6], 2'h0, an[5:0]});
        repeat (3) @(posedge mclk);
        chk("analog", {post_tap1, output_drive_level}, an);
        wb(`TLBC_OFS_ANALOG, 1'h0, 32'h0);
        chk("analog_rd", q, {19'h0, an[10:6], 2'h0, an[5:0]});
      end
    end
    // control write without lane 0 must leave the control bits alone
    wb_sel_i <= 4'hE;
    wb(`TLBC_OFS_CTRL, 1'h1, {30'h0, ~k});
    wb_sel_i <= 4'hF;
    wb(`TLBC_OFS_CTRL, 1'h0, 32'h0);
    chk("ctrl_sel", q, {30'h0, k});
    give_verdict;
  end
  // cut a hang short
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    give_verdict;
  end
endmodule // testbench
